/* opa_pkg.sv */
// constants and types for the output processing accumulator
// Operation
// - decode range code: tens digit picks integration, units digit picks full scale
// - overranged input stores most negative value, -99999 high or -6999 low resolution
// - repetition count N walks N consecutive channels and N consecutive locations
// - indexed location or port operand adds the current loop counter
// - loop counter advances by 1 unless a step-change operation set another step
// - each averaging execution with flag 9 low increments its count and adds input to its total
// - with output flag set, total divided by count goes to final storage
// - after writing an average, its total and count return to zero
// - one sample per output operation execution, not per measurement update
// - flag 9 high suppresses accumulation but final processing still runs
// - processed values are written only while output flag 0 is high
// - output goes to final area 1 by default, selectable to area 2 or input
// - operands are float, four-digit integer or two-digit integer by position
// - each table pass start forces flags 0 and 9 low
// - failed test drives flag 0 or 9 low, leaves flags 1 to 8 alone
package opa_pkg;
  typedef logic [31:0] opa_float_type;
  typedef logic [13:0] opa_int4_type;
  typedef logic [6:0] opa_int2_type;
  typedef enum logic [2:0] {
    OPA_OP_TABLE_START,
    OPA_OP_FLAG_TEST,
    OPA_OP_LOOP_STEP,
    OPA_OP_SET_STEP,
    OPA_OP_SET_DEST,
    OPA_OP_PORT,
    OPA_OP_MEASURE,
    OPA_OP_AVERAGE
  } opa_op_type;
  localparam logic [1:0] OPA_DEST_INPUT = 2'h0;
  localparam logic [1:0] OPA_DEST_FS1 = 2'h1;
  localparam logic [1:0] OPA_DEST_FS2 = 2'h2;
  localparam logic [13:0] OPA_STEP_DEFAULT = 14'h0001;
  localparam logic [31:0] OPA_OVER_HIGH = 32'hfffe7961;
  localparam logic [31:0] OPA_OVER_LOW = 32'hffffe4a9;
  localparam logic [3:0] OPA_TENS_MAX = 4'h3;
  localparam logic [3:0] OPA_UNITS_MIN = 4'h1;
  localparam logic [3:0] OPA_UNITS_MAX = 4'h5;
  localparam logic [3:0] OPA_FLAG_OUT = 4'h0;
  localparam logic [3:0] OPA_FLAG_NOACC = 4'h9;
  // full scale per units digit 1..5, in microvolts
  localparam logic [31:0] OPA_FS_UV [5] = '{32'h000009c4, 32'h00001d4c, 32'h000061a8,
                                           32'h0003d090, 32'h002625a0};
  localparam logic [7:0] OPA_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OPA_ADDR_FLAGS = 8'h04;
  localparam logic [7:0] OPA_ADDR_LOOP = 8'h08;
  localparam logic [7:0] OPA_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] OPA_ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] OPA_ADDR_IRQ_MASK = 8'h14;
  localparam int OPA_EV_AVG = 0;
  localparam int OPA_EV_OVER = 1;
  localparam int OPA_EV_BADRANGE = 2;
  localparam int OPA_EV_W = 3;
  localparam logic [1:0] OPA_RESP_OKAY = 2'h0;
  localparam logic [1:0] OPA_RESP_SLVERR = 2'h2;
endpackage : opa_pkg

/* opa_props.sv */
// concurrent checks on the accumulator executor, flag and storage ports
`timescale 1ns/1ps
`default_nettype none
module opa_props #(
  parameter int NSLOT = 16,
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire opa_pkg::opa_op_type op_code,
  input wire opa_pkg::opa_int2_type op_range,
  input wire opa_pkg::opa_int2_type op_flag,
  input wire logic op_cond,
  input wire logic req_valid,
  input wire logic req_measure,
  input wire logic [2:0] req_scale,
  input wire logic resp_valid,
  input wire logic resp_over,
  input wire logic wr_valid,
  input wire logic [31:0] wr_data,
  input wire logic [9:0] flags,
  input wire logic [13:0] loop_count
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take(opa_pkg::opa_op_type c);
    op_valid && op_ready && op_code == c;
  endsequence
  sequence s_over_resp;
    resp_valid && resp_over && req_measure;
  endsequence
  sequence s_fail(logic tgt);
    s_take(opa_pkg::OPA_OP_FLAG_TEST) ##0 (!op_cond && tgt);
  endsequence
  a_over_negmax: assert property (s_over_resp ##1 wr_valid |->
    wr_data == opa_pkg::OPA_OVER_HIGH || wr_data == opa_pkg::OPA_OVER_LOW)
    else $error("overranged result not stored as negative limit");
  a_write_after_resp: assert property (wr_valid |-> $past(resp_valid))
    else $error("write without a preceding response");
  a_req_scale_ok: assert property (req_valid && req_measure |-> req_scale <= 3'h4)
    else $error("measure request with scale out of table");
  a_bad_range_quiet: assert property (s_take(opa_pkg::OPA_OP_MEASURE) ##0
    (op_range / 7'd10 > 7'd3 || op_range % 7'd10 == 7'd0 || op_range % 7'd10 > 7'd5)
    |=> !req_valid [*3])
    else $error("request issued for invalid range code");
  a_start_clears: assert property (s_take(opa_pkg::OPA_OP_TABLE_START) |->
    ##[1:2] (!flags[0] && !flags[9]))
    else $error("table start left dedicated flag high");
  a_fail_drops_out: assert property (s_fail(op_flag == 7'd0) |-> ##[1:2] !flags[0])
    else $error("failed test left output flag high");
  a_fail_keeps_user: assert property (s_fail(op_flag >= 7'd1 && op_flag <= 7'd8)
    |=> $stable(flags[8:1]) [*2])
    else $error("failed test changed a user flag");
  a_loop_clear: assert property (s_take(opa_pkg::OPA_OP_LOOP_STEP) ##0 op_cond |->
    ##[1:2] loop_count == 14'h0)
    else $error("loop counter not cleared");
  a_reset_state: assert property ($rose(aresetn) |->
    flags == 10'h0 && loop_count == 14'h0 && op_ready && !wr_valid)
    else $error("state not cleared by reset");
  a_busy_while_req: assert property (req_valid |-> !op_ready ##1 !op_ready)
    else $error("executor ready while request pending");
endmodule : opa_props
bind opa_top opa_props #(.NSLOT(NSLOT), .CNT_W(CNT_W)) i_props (.aclk(aclk),
  .aresetn(aresetn), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
  .op_range(op_range), .op_flag(op_flag), .op_cond(op_cond), .req_valid(req_valid),
  .req_measure(req_measure), .req_scale(req_scale), .resp_valid(resp_valid),
  .resp_over(resp_over), .wr_valid(wr_valid), .wr_data(wr_data), .flags(flags),
  .loop_count(loop_count));
`default_nettype wire

/* opa_sense_model.sv */
// far-side model: answers measure and input reads after a programmable lag
`timescale 1ns/1ps
`default_nettype none
module opa_sense_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_valid,
  input wire logic [13:0] req_addr,
  input wire logic [3:0] lag,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic resp_over
);
  logic [13:0] addr_q;
  logic [3:0] wait_q;
  logic busy_q;
  initial begin
    resp_valid = 1'b0;
    resp_data = 32'h0;
    resp_over = 1'b0;
    busy_q = 1'b0;
  end
  always @(posedge aclk) begin
    resp_valid <= 1'b0;
    resp_data <= ~resp_data;
    resp_over <= ~resp_over;
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (req_valid) begin
      busy_q <= 1'b1;
      addr_q <= req_addr;
      wait_q <= lag;
    end else if (busy_q && wait_q == 4'h0) begin
      busy_q <= 1'b0;
      resp_valid <= 1'b1;
      resp_data <= {18'h0, addr_q} * 32'h10 + 32'h7;
      resp_over <= (addr_q == 14'd99);
    end else if (busy_q) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule : opa_sense_model
`default_nettype wire

/* opa_top.sv */
// output processing accumulator with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module opa_top #(
  parameter int NSLOT = 16,
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  output logic op_ready,
  input wire opa_pkg::opa_op_type op_code,
  input wire opa_pkg::opa_int2_type op_reps,
  input wire opa_pkg::opa_int2_type op_range,
  input wire opa_pkg::opa_int2_type op_flag,
  input wire logic op_cond,
  input wire opa_pkg::opa_int4_type op_chan,
  input wire opa_pkg::opa_int4_type op_loc,
  input wire logic op_indexed,
  input wire opa_pkg::opa_int4_type op_slot,
  input wire opa_pkg::opa_float_type float_operand,
  output logic req_valid,
  output logic req_measure,
  output logic [13:0] req_addr,
  output logic [1:0] req_mode,
  output logic [2:0] req_scale,
  input wire logic resp_valid,
  input wire logic [31:0] resp_data,
  input wire logic resp_over,
  output logic wr_valid,
  output logic [1:0] wr_area,
  output logic [13:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [9:0] flags,
  output logic [13:0] loop_count,
  output logic [7:0] ports,
  output logic irq
);
  localparam int SW = $clog2(NSLOT);

  if (NSLOT < 2 || NSLOT > 1024 || CNT_W < 2 || CNT_W > 31) begin : g_param_check
    $error("opa_top: unsupported NSLOT or CNT_W");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_NEXT} opa_state_type;

  typedef struct packed {
    opa_state_type st;
    logic [6:0] rep_i;
    logic [6:0] reps;
    logic is_meas;
    logic [13:0] chan;
    logic [13:0] loc;
    logic [SW-1:0] slot;
    logic [31:0] offset;
    logic [9:0] flag;
    logic [13:0] loop_cnt;
    logic [13:0] step;
    logic [1:0] dest;
    logic hires;
    logic [7:0] port;
    logic op_ready;
    logic req_valid;
    logic [13:0] req_addr;
    logic [1:0] req_mode;
    logic [2:0] req_scale;
    logic wr_valid;
    logic [1:0] wr_area;
    logic [13:0] wr_addr;
    logic [31:0] wr_data;
    logic [NSLOT-1:0][31:0] sum;
    logic [NSLOT-1:0][CNT_W-1:0] cnt;
    logic [opa_pkg::OPA_EV_W-1:0] irq_stat;
    logic [opa_pkg::OPA_EV_W-1:0] irq_mask;
    logic irq;
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } opa_state_reg_type;

  opa_state_reg_type s_q;
  opa_state_reg_type s_d;

  // operand plus loop counter when indexed
  function automatic logic [13:0] eff_addr(input logic [13:0] base, input logic idx,
                                           input logic [13:0] lc);
    eff_addr = idx ? 14'(base + lc) : base;
  endfunction : eff_addr

  // quotient of a running total over its sample count, zero on empty count
  function automatic logic [31:0] avg_of(input logic [31:0] total, input logic [CNT_W-1:0] n);
    logic [31:0] den;
    den = 32'(n);
    if (n == '0) begin
      avg_of = 32'h0;
    end else begin
      avg_of = 32'($signed(total) / $signed(den));
    end
  endfunction : avg_of

  logic [3:0] tens;
  logic [3:0] units;
  logic range_ok;
  logic [31:0] mag;
  logic over;
  logic [31:0] new_sum;
  logic [CNT_W-1:0] new_cnt;
  logic aw_take;
  logic ar_take;
  logic [opa_pkg::OPA_EV_W-1:0] ev;
  logic [opa_pkg::OPA_EV_W-1:0] clr;

  always_comb begin
    s_d = s_q;
    ev = '0;
    clr = '0;
    tens = 4'(op_range / 7'd10);
    units = 4'(op_range % 7'd10);
    range_ok = (tens <= opa_pkg::OPA_TENS_MAX) && (units >= opa_pkg::OPA_UNITS_MIN)
               && (units <= opa_pkg::OPA_UNITS_MAX);
    mag = resp_data[31] ? 32'(-resp_data) : resp_data;
    over = resp_over || (mag > opa_pkg::OPA_FS_UV[3'(s_q.req_scale)]);
    new_sum = 32'(s_q.sum[s_q.slot] + resp_data);
    new_cnt = CNT_W'(s_q.cnt[s_q.slot] + 1'b1);
    s_d.req_valid = 1'b0;
    s_d.wr_valid = 1'b0;
    // executor operations
    case (s_q.st)
      ST_IDLE: begin
        if (op_valid) begin
          case (op_code)
            opa_pkg::OPA_OP_TABLE_START: begin
              s_d.flag[opa_pkg::OPA_FLAG_OUT] = 1'b0;
              s_d.flag[opa_pkg::OPA_FLAG_NOACC] = 1'b0;
            end
            opa_pkg::OPA_OP_FLAG_TEST: begin
              if (op_flag <= 7'd9) begin
                if (op_cond) begin
                  s_d.flag[4'(op_flag)] = 1'b1;
                end else if (op_flag == 7'(opa_pkg::OPA_FLAG_OUT)
                             || op_flag == 7'(opa_pkg::OPA_FLAG_NOACC)) begin
                  s_d.flag[4'(op_flag)] = 1'b0;
                end
              end
            end
            opa_pkg::OPA_OP_LOOP_STEP: begin
              if (op_cond) begin
                s_d.loop_cnt = 14'h0;
              end else begin
                s_d.loop_cnt = 14'(s_q.loop_cnt + s_q.step);
              end
            end
            opa_pkg::OPA_OP_SET_STEP: begin
              s_d.step = op_loc;
            end
            opa_pkg::OPA_OP_SET_DEST: begin
              if (op_flag <= 7'(opa_pkg::OPA_DEST_FS2)) begin
                s_d.dest = 2'(op_flag);
              end
            end
            opa_pkg::OPA_OP_PORT: begin
              if (eff_addr(op_loc, op_indexed, s_q.loop_cnt) inside {[14'd1 : 14'd8]}) begin
                s_d.port[3'(eff_addr(op_loc, op_indexed, s_q.loop_cnt) - 14'd1)] = op_cond;
              end
            end
            default: begin
              // measure or average: walk op_reps consecutive channels and locations
              s_d.is_meas = (op_code == opa_pkg::OPA_OP_MEASURE);
              s_d.chan = eff_addr(op_chan, op_indexed, s_q.loop_cnt);
              s_d.loc = eff_addr(op_loc, op_indexed, s_q.loop_cnt);
              s_d.slot = SW'(op_slot);
              s_d.offset = float_operand;
              s_d.reps = op_reps;
              s_d.rep_i = 7'h0;
              s_d.req_mode = 2'(tens);
              s_d.req_scale = 3'(units - 4'h1);
              if (op_code == opa_pkg::OPA_OP_MEASURE && !range_ok) begin
                ev[opa_pkg::OPA_EV_BADRANGE] = 1'b1;
              end else if (op_reps != 7'h0) begin
                s_d.req_valid = 1'b1;
                s_d.req_addr = s_d.chan;
                s_d.op_ready = 1'b0;
                s_d.st = ST_WAIT;
              end
            end
          endcase
        end
      end
      ST_WAIT: begin
        if (resp_valid) begin
          if (s_q.is_meas) begin
            s_d.wr_valid = 1'b1;
            s_d.wr_area = opa_pkg::OPA_DEST_INPUT;
            s_d.wr_addr = 14'(s_q.loc + 14'(s_q.rep_i));
            if (over) begin
              s_d.wr_data = s_q.hires ? opa_pkg::OPA_OVER_HIGH : opa_pkg::OPA_OVER_LOW;
              ev[opa_pkg::OPA_EV_OVER] = 1'b1;
            end else begin
              s_d.wr_data = 32'(resp_data + s_q.offset);
            end
          end else begin
            if (!s_q.flag[opa_pkg::OPA_FLAG_NOACC]) begin
              s_d.sum[s_q.slot] = new_sum;
              s_d.cnt[s_q.slot] = new_cnt;
            end else begin
              new_sum = s_q.sum[s_q.slot];
              new_cnt = s_q.cnt[s_q.slot];
            end
            if (s_q.flag[opa_pkg::OPA_FLAG_OUT]) begin
              s_d.wr_valid = 1'b1;
              s_d.wr_area = s_q.dest;
              s_d.wr_addr = 14'(s_q.loc + 14'(s_q.rep_i));
              s_d.wr_data = avg_of(new_sum, new_cnt);
              s_d.sum[s_q.slot] = 32'h0;
              s_d.cnt[s_q.slot] = '0;
              ev[opa_pkg::OPA_EV_AVG] = 1'b1;
            end
          end
          s_d.st = ST_NEXT;
        end
      end
      default: begin
        if (7'(s_q.rep_i + 7'h1) >= s_q.reps) begin
          s_d.st = ST_IDLE;
          s_d.op_ready = 1'b1;
        end else begin
          s_d.rep_i = 7'(s_q.rep_i + 7'h1);
          s_d.slot = SW'(s_q.slot + 1'b1);
          s_d.req_valid = 1'b1;
          s_d.req_addr = 14'(s_q.chan + 14'(s_q.rep_i) + 14'h1);
          s_d.st = ST_WAIT;
        end
      end
    endcase
    // axi4-lite write channel: address and data taken together
    aw_take = s_axi_awvalid && s_axi_wvalid && !s_q.awready && !s_q.bvalid;
    s_d.awready = aw_take;
    if (aw_take) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = opa_pkg::OPA_RESP_OKAY;
      if (s_axi_awaddr == opa_pkg::OPA_ADDR_CTRL) begin
        if (s_axi_wstrb[0]) begin
          s_d.hires = s_axi_wdata[0];
        end
      end else if (s_axi_awaddr == opa_pkg::OPA_ADDR_FLAGS) begin
        if (s_axi_wstrb[0]) begin
          s_d.flag[8:1] = s_axi_wdata[8:1];
        end
      end else if (s_axi_awaddr == opa_pkg::OPA_ADDR_IRQ_STAT) begin
        if (s_axi_wstrb[0]) begin
          clr = s_axi_wdata[opa_pkg::OPA_EV_W-1:0];
        end
      end else if (s_axi_awaddr == opa_pkg::OPA_ADDR_IRQ_MASK) begin
        if (s_axi_wstrb[0]) begin
          s_d.irq_mask = s_axi_wdata[opa_pkg::OPA_EV_W-1:0];
        end
      end else if (s_axi_awaddr == opa_pkg::OPA_ADDR_LOOP
                   || s_axi_awaddr == opa_pkg::OPA_ADDR_STATUS) begin
        s_d.bresp = opa_pkg::OPA_RESP_OKAY;
      end else begin
        s_d.bresp = opa_pkg::OPA_RESP_SLVERR;
      end
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // axi4-lite read channel
    ar_take = s_axi_arvalid && !s_q.arready && !s_q.rvalid;
    s_d.arready = ar_take;
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = opa_pkg::OPA_RESP_OKAY;
      s_d.rdata = 32'h0;
      if (s_axi_araddr == opa_pkg::OPA_ADDR_CTRL) begin
        s_d.rdata[0] = s_q.hires;
      end else if (s_axi_araddr == opa_pkg::OPA_ADDR_FLAGS) begin
        s_d.rdata[9:0] = s_q.flag;
      end else if (s_axi_araddr == opa_pkg::OPA_ADDR_LOOP) begin
        s_d.rdata = {2'h0, s_q.step, 2'h0, s_q.loop_cnt};
      end else if (s_axi_araddr == opa_pkg::OPA_ADDR_STATUS) begin
        s_d.rdata[10:0] = {s_q.port, s_q.dest, ~s_q.op_ready};
      end else if (s_axi_araddr == opa_pkg::OPA_ADDR_IRQ_STAT) begin
        s_d.rdata[opa_pkg::OPA_EV_W-1:0] = s_q.irq_stat;
      end else if (s_axi_araddr == opa_pkg::OPA_ADDR_IRQ_MASK) begin
        s_d.rdata[opa_pkg::OPA_EV_W-1:0] = s_q.irq_mask;
      end else begin
        s_d.rresp = opa_pkg::OPA_RESP_SLVERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // sticky events, a new event wins over a same-cycle clear
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.op_ready <= 1'b1;
      s_q.step <= opa_pkg::OPA_STEP_DEFAULT;
      s_q.dest <= opa_pkg::OPA_DEST_FS1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.awready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign op_ready = s_q.op_ready;
  assign req_valid = s_q.req_valid;
  assign req_measure = s_q.is_meas;
  assign req_addr = s_q.req_addr;
  assign req_mode = s_q.req_mode;
  assign req_scale = s_q.req_scale;
  assign wr_valid = s_q.wr_valid;
  assign wr_area = s_q.wr_area;
  assign wr_addr = s_q.wr_addr;
  assign wr_data = s_q.wr_data;
  assign flags = s_q.flag;
  assign loop_count = s_q.loop_cnt;
  assign ports = s_q.port;
  assign irq = s_q.irq;
endmodule : opa_top
`default_nettype wire

/* output_processing_accumulator_tb.sv */
// self-checking bench for the output processing accumulator
`timescale 1ns/1ps
`default_nettype none
module output_processing_accumulator_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic rry = 1'b0, opv = 1'b0, opc = 1'b0, opi = 1'b0, hires = 1'b0;
  logic [7:0] awa = 8'h0, ara = 8'h0, pt;
  logic [31:0] wd = 32'h0, fo = 32'h0, rd, rsd, wrd;
  logic awr, wrr, bv, arr, rv, opr, rqv, rqm, wrv, irq, rsv, rso;
  logic [1:0] br, rr, rqmode, wra, dst = 2'h1;
  logic [13:0] rqa, wraddr, lc;
  logic [2:0] rqs;
  logic [9:0] fl, ef = 10'h0;
  logic [3:0] lag = 4'h0;
  opa_pkg::opa_op_type opcode = opa_pkg::OPA_OP_TABLE_START;
  opa_pkg::opa_int2_type reps = 7'h0, rng = 7'h0, flg = 7'h0;
  opa_pkg::opa_int4_type ch = 14'h0, loc = 14'h0, slot = 14'h0;
  int failures = 0, checks = 0, lcnt = 0, tot[16], cnt[16];
  int codes[9] = '{1, 11, 21, 31, 12, 23, 34, 35, 5};
  logic [47:0] q_wr[$];
  logic [33:0] q_bus[$], bx;
  logic [19:0] q_req[$];
  always #10 aclk = ~aclk;
  opa_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .op_valid(opv), .op_ready(opr),
    .op_code(opcode), .op_reps(reps), .op_range(rng), .op_flag(flg), .op_cond(opc),
    .op_chan(ch), .op_loc(loc), .op_indexed(opi), .op_slot(slot), .float_operand(fo),
    .req_valid(rqv), .req_measure(rqm), .req_addr(rqa), .req_mode(rqmode), .req_scale(rqs),
    .resp_valid(rsv), .resp_data(rsd), .resp_over(rso), .wr_valid(wrv), .wr_area(wra),
    .wr_addr(wraddr), .wr_data(wrd), .flags(fl), .loop_count(lc), .ports(pt), .irq(irq));
  opa_sense_model i_far (.aclk(aclk), .aresetn(aresetn), .req_valid(rqv), .req_addr(rqa),
    .lag(lag), .resp_valid(rsv), .resp_data(rsd), .resp_over(rso));
  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  always @(posedge aclk) begin
    if (wrv === 1'b1) chk("write", {wra, wraddr, wrd}, q_wr.size() ? q_wr.pop_front() : 'x);
    if (rqv === 1'b1) chk("request", 48'({rqm, rqm ? {rqmode, rqs} : 5'h0, rqa}),
      q_req.size() ? 48'(q_req.pop_front()) : 'x);
    if (rv === 1'b1 && rry === 1'b1) chk("read", 48'({rr, rd}), 48'(q_bus.pop_front()));
    if (bv === 1'b1 && bry === 1'b1) begin
      bx = q_bus.pop_front();
      chk("bresp", 48'(br), 48'(bx[33:32]));
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    q_bus.push_back({a > 8'h14 ? opa_pkg::OPA_RESP_SLVERR : opa_pkg::OPA_RESP_OKAY, 32'h0});
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    q_bus.push_back(e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
  endtask : axr
  task automatic op(input opa_pkg::opa_op_type c, input int f, input logic k);
    @(posedge aclk);
    opcode <= c;
    flg <= 7'(f);
    opc <= k;
    opv <= 1'b1;
    do @(posedge aclk); while (opr !== 1'b1);
    opv <= 1'b0;
    repeat (2) @(posedge aclk);
    while (opr !== 1'b1) @(posedge aclk);
  endtask : op
  task automatic flag(input int n, input logic k);
    op(opa_pkg::OPA_OP_FLAG_TEST, n, k);
    if (k || n == 0 || n == 9) ef[n] = k;
    chk("flags", 48'(fl), 48'(ef));
  endtask : flag
  task automatic meas(input int cd, input int n, input int c, input int l, input logic ix);
    int a;
    logic [31:0] e;
    for (int i = 0; i < n; i++) begin
      a = c + i + (ix ? lcnt : 0);
      e = (a == 99 || a * 16 + 7 > opa_pkg::OPA_FS_UV[cd % 10 - 1]) ?
        (hires ? opa_pkg::OPA_OVER_HIGH : opa_pkg::OPA_OVER_LOW) : a * 16 + 7 + fo;
      q_req.push_back({1'b1, 2'(cd / 10), 3'(cd % 10 - 1), 14'(a)});
      q_wr.push_back({opa_pkg::OPA_DEST_INPUT, 14'(l + i + (ix ? lcnt : 0)), e});
    end
    lag <= 4'($urandom % 6);
    rng <= 7'(cd);
    reps <= 7'(n);
    ch <= 14'(c);
    loc <= 14'(l);
    opi <= ix;
    op(opa_pkg::OPA_OP_MEASURE, 0, 1'b0);
  endtask : meas
  task automatic avg(input int n, input int c, input int s);
    int k;
    for (int i = 0; i < n; i++) begin
      k = (s + i) % 16;
      q_req.push_back({6'h0, 14'(c + i)});
      if (!ef[9]) tot[k] += (c + i) * 16 + 7;
      if (!ef[9]) cnt[k] += 1;
      if (ef[0]) q_wr.push_back({dst, 14'(60 + i), 32'(cnt[k] ? tot[k] / cnt[k] : 0)});
      if (ef[0]) tot[k] = 0;
      if (ef[0]) cnt[k] = 0;
    end
    reps <= 7'(n);
    ch <= 14'(c);
    loc <= 14'd60;
    slot <= 14'(s);
    op(opa_pkg::OPA_OP_AVERAGE, 0, 1'b0);
  endtask : avg
  initial begin
    void'($urandom(36117));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axw(opa_pkg::OPA_ADDR_LOOP, 32'h5);
    axr(opa_pkg::OPA_ADDR_LOOP, 34'h000010000);
    axr(opa_pkg::OPA_ADDR_STATUS, 34'h2);
    axr(8'h40, {opa_pkg::OPA_RESP_SLVERR, 32'h0});
    axw(8'h40, 32'h1);
    axw(opa_pkg::OPA_ADDR_IRQ_MASK, 32'h4);
    for (int j = 0; j < 2; j++) begin
      rng <= j ? 7'd40 : 7'd16;
      reps <= 7'd1;
      op(opa_pkg::OPA_OP_MEASURE, 0, 1'b0);
      chk("irq", 48'(irq), 48'(j == 0));
      axr(opa_pkg::OPA_ADDR_IRQ_STAT, 34'h4);
      axw(opa_pkg::OPA_ADDR_IRQ_STAT, 32'h4);
      axw(opa_pkg::OPA_ADDR_IRQ_MASK, 32'h0);
      @(posedge aclk);
      chk("irq", 48'(irq), 48'h0);
    end
    $display("test interrupts done");
    fo <= 32'($urandom % 100000);
    @(posedge aclk);
    foreach (codes[j]) meas(codes[j], 1, 5, 40, 1'b0);
    meas(15, 3, 7, 41, 1'b0);
    meas(1, 1, 200, 42, 1'b0);
    axw(opa_pkg::OPA_ADDR_CTRL, 32'h1);
    hires = 1'b1;
    meas(15, 1, 99, 43, 1'b0);
    $display("test measure done");
    op(opa_pkg::OPA_OP_LOOP_STEP, 0, 1'b0);
    chk("loop", 48'(lc), 48'h1);
    op(opa_pkg::OPA_OP_LOOP_STEP, 0, 1'b1);
    loc <= 14'd3;
    op(opa_pkg::OPA_OP_SET_STEP, 0, 1'b0);
    op(opa_pkg::OPA_OP_LOOP_STEP, 0, 1'b0);
    lcnt = 3;
    axr(opa_pkg::OPA_ADDR_LOOP, 34'h000030003);
    meas(15, 1, 10, 20, 1'b1);
    loc <= 14'd2;
    op(opa_pkg::OPA_OP_PORT, 0, 1'b1);
    opi <= 1'b0;
    loc <= 14'd1;
    op(opa_pkg::OPA_OP_PORT, 0, 1'b1);
    chk("ports", 48'(pt), 48'h11);
    op(opa_pkg::OPA_OP_PORT, 0, 1'b0);
    chk("ports", 48'(pt), 48'h10);
    $display("test loop done");
    flag(0, 1'b1);
    flag(3, 1'b1);
    flag(3, 1'b0);
    flag(9, 1'b1);
    flag(0, 1'b0);
    op(opa_pkg::OPA_OP_TABLE_START, 0, 1'b0);
    ef[9] = 1'b0;
    chk("flags", 48'(fl), 48'(ef));
    axw(opa_pkg::OPA_ADDR_FLAGS, 32'h3ff);
    ef[8:1] = 8'hff;
    axr(opa_pkg::OPA_ADDR_FLAGS, 34'h1fe);
    axw(opa_pkg::OPA_ADDR_FLAGS, 32'h0);
    ef = 10'h0;
    $display("test flags done");
    avg(2, 30, 2);
    avg(2, 30, 2);
    flag(9, 1'b1);
    avg(2, 30, 2);
    flag(0, 1'b1);
    avg(2, 30, 2);
    avg(1, 30, 2);
    op(opa_pkg::OPA_OP_SET_DEST, 2, 1'b0);
    dst = opa_pkg::OPA_DEST_FS2;
    flag(9, 1'b0);
    avg(1, 31, 5);
    op(opa_pkg::OPA_OP_SET_DEST, 0, 1'b0);
    op(opa_pkg::OPA_OP_SET_DEST, 3, 1'b0);
    dst = opa_pkg::OPA_DEST_INPUT;
    avg(1, 32, 6);
    axr(opa_pkg::OPA_ADDR_STATUS, 34'h80);
    axr(opa_pkg::OPA_ADDR_IRQ_STAT, 34'h3);
    $display("test average done");
    chk("left", 48'(q_wr.size() + q_req.size()), 48'h0);
    summarize();
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule : output_processing_accumulator_tb
`default_nettype wire
